// ===== link_defs.svh
// constants shared by both ends of the scratch-pad command link
// assumes: included by bare name, after the package where types are needed
`ifndef LINK_DEFS_SVH
`define LINK_DEFS_SVH

// ----------
// scratch-pad map and sub-commands
// ----------
`define SP_TYPE 4'h6
`define SP_SUBCMD_ADDR 16'h0002
`define SP_RESULT_ADDR 16'h0004
`define SUB_CHECK 16'h0003
`define SUB_LOCATE 16'h0006
`define SUB_LOGIN 16'h0009
`define SUB_CHANGE 16'h000A
`define NO_PASSWORD 16'h0000
`define RESULT_RESET 16'h0000

// ----------
// write lengths in bytes and password byte positions
// ----------
`define LONG_LEN 4'hA
`define SHORT_LEN 4'h2
`define PW_HI_IDX 4'h8
`define PW_LO_IDX 4'h9

// ----------
// program scan
// ----------
`define PROG_LAST 16'h03FF

// ----------
// host register offsets and fields
// ----------
`define REG_CTRL 8'h00
`define REG_PASSWORD 8'h04
`define REG_TARGET 8'h08
`define REG_WDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_RESULT 8'h14
`define STAT_BUSY 0
`define STAT_OK 1
`define STAT_DONE 2
`define TGT_TYPE_LSB 16

`endif

// ===== link_pkg.sv
// types shared by both ends of the scratch-pad command link
// assumes: compiled before the interface and the ends
package link_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef logic [3:0] mem_type_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_LOGIN = 3'h1,
        OP_CHANGE = 3'h2,
        OP_CHECK = 3'h3,
        OP_LOCATE = 3'h4,
        OP_READ = 3'h5,
        OP_WRITE = 3'h6
    } op_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_WSTART = 3'h1,
        H_BYTES = 3'h3,
        H_WWAIT = 3'h2,
        H_RSTART = 3'h6,
        H_RWAIT = 3'h7
    } host_state_t;
endpackage : link_pkg

// ===== link_if.sv
// link between the link master and the controller end
// assumes: both ends run on the same pclk
`timescale 1ns/1ns
interface link_if;
    import link_pkg::*;
    logic wr_start;
    logic rd_start;
    mem_type_t mem_type;
    word_t addr;
    logic byte_valid;
    byte_t byte_data;
    logic byte_last;
    logic done;
    logic ok;
    word_t rd_data;
    modport dev (
        input wr_start, rd_start, mem_type, addr,
        input byte_valid, byte_data, byte_last,
        output done, ok, rd_data
    );
    modport host (
        output wr_start, rd_start, mem_type, addr,
        output byte_valid, byte_data, byte_last,
        input done, ok, rd_data
    );
endinterface : link_if

// ===== prog_checker.sv
// scans the user program for the first word flagged in error
// assumes: scan_code is the error code of the word at scan_addr, same cycle
`timescale 1ns/1ns
`include "link_defs.svh"
module prog_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire link_pkg::word_t scan_code,
    output link_pkg::word_t scan_addr,
    output logic busy,
    output logic done,
    output link_pkg::word_t err_code,
    output link_pkg::word_t err_loc
);
    import link_pkg::*;

    // ----------
    // walk
    // ----------
    // a new start restarts the walk even mid-scan
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            done <= 1'b0;
            scan_addr <= 16'h0000;
            err_code <= 16'h0000;
            err_loc <= 16'h0000;
        end else if (start) begin
            busy <= 1'b1;
            done <= 1'b0;
            scan_addr <= 16'h0000;
            err_code <= 16'h0000;
            err_loc <= 16'h0000;
        end else if (busy) begin
            if (scan_code != 16'h0000) begin
                err_code <= scan_code;
                err_loc <= scan_addr;
                busy <= 1'b0;
                done <= 1'b1;
            end else if (scan_addr == `PROG_LAST) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else begin
                scan_addr <= scan_addr + 16'h0001;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule : prog_checker

// ===== ctrl_end.sv
// controller end: scratch-pad sub-commands, password and program check
// assumes: link master on the same pclk keeps the byte framing
//
// What this block does
// RULE_01: password change only after successful log-in
// RULE_02: change is ten bytes from sub-command word
// RULE_03: bytes one, two carry sub-command, high first
// RULE_04: bytes three to eight are zero
// RULE_05: last two bytes: BCD password, high pair first
// RULE_06: passwords 0 to 9999; zero means unprotected
// RULE_07: program check may start at any time
// RULE_08: sub-command 0003 starts the program check
// RULE_09: result word zero or the error code
// RULE_10: sub-command 0006 selects first error location
// RULE_11: result word then gives first error position
// RULE_12: master reads result between check and locate
// RULE_13: log-in: ten bytes, code 0009, old password
// RULE_14: locked: memory types 1, 3, 7 refused
// RULE_15: result word holds until next sub-command
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "link_defs.svh"
module ctrl_end (
    input wire logic pclk,
    input wire logic presetn,
    link_if.dev lnk,
    input wire link_pkg::word_t scan_code,
    input wire link_pkg::word_t ext_rd_data,
    output link_pkg::word_t scan_addr,
    output logic logged_in,
    output logic pw_set,
    output logic check_busy
);
    import link_pkg::*;

    // ----------
    // decoding helpers
    // ----------
    function automatic logic protected_type(input mem_type_t t);
        protected_type = (t == 4'h1) || (t == 4'h3) || (t == 4'h7);
    endfunction : protected_type

    function automatic logic bcd_ok(input word_t w);
        bcd_ok = (w[15:12] < 4'hA) && (w[11:8] < 4'hA) &&
                 (w[7:4] < 4'hA) && (w[3:0] < 4'hA);
    endfunction : bcd_ok

    // ----------
    // state
    // ----------
    byte_t rx_buf [0:9];
    logic [3:0] rx_cnt_reg;
    logic rx_active_reg;
    logic rx_sp_reg;
    logic rx_deny_reg;
    logic rx_long_reg;
    logic eval_reg;
    logic rd_pend_reg;
    mem_type_t rd_type_reg;
    word_t rd_addr_reg;
    word_t pw_reg;
    word_t result_reg;
    logic check_pend_reg;
    logic chk_start;
    logic chk_done;
    word_t chk_code;
    word_t chk_loc;
    logic locked;

    assign locked = (pw_reg != `NO_PASSWORD) && !logged_in;

    // ----------
    // byte collection
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_active_reg <= 1'b0;
            rx_cnt_reg <= 4'h0;
            rx_sp_reg <= 1'b0;
            rx_deny_reg <= 1'b0;
            rx_long_reg <= 1'b0;
            eval_reg <= 1'b0;
        end else if (lnk.wr_start) begin
            rx_active_reg <= 1'b1;
            rx_cnt_reg <= 4'h0;
            rx_long_reg <= 1'b0;
            eval_reg <= 1'b0;
            rx_sp_reg <= (lnk.mem_type == `SP_TYPE) &&
                         (lnk.addr == `SP_SUBCMD_ADDR); // RULE_02
            rx_deny_reg <= protected_type(lnk.mem_type) && locked; // RULE_14
        end else if (rx_active_reg && lnk.byte_valid) begin
            if (rx_cnt_reg == `LONG_LEN) begin
                rx_long_reg <= 1'b1;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
            if (lnk.byte_last) begin
                rx_active_reg <= 1'b0;
                eval_reg <= 1'b1;
            end
        end else begin
            eval_reg <= 1'b0;
        end
    end

    // no reset: contents are only read after a full frame
    always_ff @(posedge pclk) begin
        if (rx_active_reg && lnk.byte_valid && rx_cnt_reg < `LONG_LEN) begin
            rx_buf[rx_cnt_reg] <= lnk.byte_data;
        end
    end

    // ----------
    // frame decode
    // ----------
    word_t sub;
    word_t pw_field;
    logic pad_zero;
    logic is_long;
    logic is_short;
    logic do_login;
    logic do_change;
    logic do_check;
    logic do_locate;
    logic frame_ok;

    always_comb begin
        sub = {rx_buf[0], rx_buf[1]}; // RULE_03
        pw_field = {rx_buf[`PW_HI_IDX], rx_buf[`PW_LO_IDX]}; // RULE_05
        pad_zero = 1'b1;
        for (int i = 2; i < 8; i++) begin
            if (rx_buf[i] != 8'h00) begin
                pad_zero = 1'b0; // RULE_04
            end
        end
        is_long = rx_sp_reg && !rx_long_reg && rx_cnt_reg == `LONG_LEN &&
                  pad_zero && bcd_ok(pw_field); // RULE_06
        is_short = rx_sp_reg && rx_cnt_reg == `SHORT_LEN;
        do_login = eval_reg && is_long && sub == `SUB_LOGIN; // RULE_13
        do_change = eval_reg && is_long && sub == `SUB_CHANGE && logged_in;
        do_check = eval_reg && is_short && sub == `SUB_CHECK; // RULE_08
        do_locate = eval_reg && is_short && sub == `SUB_LOCATE; // RULE_10
        if (rx_sp_reg) begin
            frame_ok = do_login ? (pw_field == pw_reg) :
                       (do_change || do_check || do_locate);
        end else begin
            frame_ok = !rx_deny_reg && !rx_long_reg; // RULE_14
        end
    end

    assign chk_start = do_check; // RULE_07

    // ----------
    // password and log-in
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_reg <= `NO_PASSWORD;
            logged_in <= 1'b0;
            pw_set <= 1'b0;
        end else begin
            if (do_login) begin
                logged_in <= (pw_field == pw_reg); // RULE_13
            end
            if (do_change) begin
                pw_reg <= pw_field; // RULE_01
                pw_set <= (pw_field != `NO_PASSWORD); // RULE_06
            end
        end
    end

    // ----------
    // result word
    // ----------
    // a late check finish must not overwrite a location read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= `RESULT_RESET;
            check_pend_reg <= 1'b0;
        end else if (do_check) begin
            check_pend_reg <= 1'b1;
        end else if (do_locate) begin
            check_pend_reg <= 1'b0;
            result_reg <= chk_loc; // RULE_11
        end else if (check_pend_reg && chk_done) begin
            check_pend_reg <= 1'b0;
            result_reg <= chk_code; // RULE_09 RULE_15
        end
    end

    // ----------
    // reads
    // ----------
    logic rd_is_result;
    logic rd_ready;

    assign rd_is_result = rd_type_reg == `SP_TYPE &&
                          rd_addr_reg == `SP_RESULT_ADDR;
    // result reads wait for a running check to finish
    assign rd_ready = rd_pend_reg && !(rd_is_result && check_pend_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_reg <= 1'b0;
            rd_type_reg <= 4'h0;
            rd_addr_reg <= 16'h0000;
        end else if (lnk.rd_start) begin
            rd_pend_reg <= 1'b1;
            rd_type_reg <= lnk.mem_type;
            rd_addr_reg <= lnk.addr;
        end else if (rd_ready) begin
            rd_pend_reg <= 1'b0;
        end
    end

    // ----------
    // answers
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lnk.done <= 1'b0;
            lnk.ok <= 1'b0;
            lnk.rd_data <= 16'h0000;
        end else if (eval_reg) begin
            lnk.done <= 1'b1;
            lnk.ok <= frame_ok;
        end else if (rd_ready) begin
            lnk.done <= 1'b1;
            if (rd_type_reg == `SP_TYPE) begin
                lnk.ok <= rd_is_result;
                lnk.rd_data <= rd_is_result ? result_reg : 16'h0000; // RULE_12
            end else begin
                lnk.ok <= !(protected_type(rd_type_reg) && locked); // RULE_14
                lnk.rd_data <= ext_rd_data;
            end
        end else begin
            lnk.done <= 1'b0;
        end
    end

    // ----------
    // program checker
    // ----------
    prog_checker u_checker (
        .pclk(pclk),
        .presetn(presetn),
        .start(chk_start),
        .scan_code(scan_code),
        .scan_addr(scan_addr),
        .busy(check_busy),
        .done(chk_done),
        .err_code(chk_code),
        .err_loc(chk_loc)
    );
endmodule : ctrl_end

// ===== host_end.sv
// link master end: APB registers turned into scratch-pad command frames
// assumes: APB master on pclk; far end answers every frame with done
`timescale 1ns/1ns
`include "link_defs.svh"
module host_end (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    link_if.host lnk
);
    import link_pkg::*;

    // ----------
    // frame bytes
    // ----------
    function automatic byte_t frame_byte(input logic [3:0] idx,
                                         input word_t sub,
                                         input word_t pw);
        case (idx)
            4'h0: frame_byte = sub[15:8]; // RULE_03
            4'h1: frame_byte = sub[7:0];
            `PW_HI_IDX: frame_byte = pw[15:8]; // RULE_05
            `PW_LO_IDX: frame_byte = pw[7:0];
            default: frame_byte = 8'h00; // RULE_04
        endcase
    endfunction : frame_byte

    host_state_t state_reg;
    op_t op_reg;
    word_t pw_reg;
    logic [19:0] tgt_reg;
    word_t wdata_reg;
    word_t result_reg;
    logic ok_reg;
    logic done_reg;
    logic [3:0] idx_reg;
    word_t sub;
    logic [3:0] len;
    logic acc;
    logic go;

    assign acc = psel && penable && pready;
    assign go = acc && pwrite && paddr == `REG_CTRL &&
                state_reg == H_IDLE && pwdata[2:0] != 3'h0;

    always_comb begin
        case (op_reg)
            OP_LOGIN: sub = `SUB_LOGIN; // RULE_13
            OP_CHANGE: sub = `SUB_CHANGE; // RULE_01
            OP_CHECK: sub = `SUB_CHECK; // RULE_08
            OP_LOCATE: sub = `SUB_LOCATE; // RULE_10
            default: sub = wdata_reg;
        endcase
        len = (op_reg == OP_LOGIN || op_reg == OP_CHANGE) ?
              `LONG_LEN : `SHORT_LEN; // RULE_02
    end

    // ----------
    // APB slave
    // ----------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            case (paddr)
                `REG_PASSWORD: prdata <= {16'h0000, pw_reg};
                `REG_TARGET: prdata <= {12'h000, tgt_reg};
                `REG_WDATA: prdata <= {16'h0000, wdata_reg};
                `REG_STATUS: prdata <= {29'h00000000, done_reg, ok_reg,
                                        state_reg != H_IDLE};
                `REG_RESULT: prdata <= {16'h0000, result_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pw_reg <= 16'h0000;
            tgt_reg <= 20'h00000;
            wdata_reg <= 16'h0000;
        end else if (acc && pwrite) begin
            case (paddr)
                `REG_PASSWORD: pw_reg <= pwdata[15:0];
                `REG_TARGET: tgt_reg <= pwdata[19:0];
                `REG_WDATA: wdata_reg <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ----------
    // command sequencer
    // ----------
    // done sticks until software writes one to it; a finish wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= H_IDLE;
            op_reg <= OP_NONE;
            idx_reg <= 4'h0;
            ok_reg <= 1'b0;
            done_reg <= 1'b0;
            result_reg <= 16'h0000;
            lnk.wr_start <= 1'b0;
            lnk.rd_start <= 1'b0;
            lnk.mem_type <= 4'h0;
            lnk.addr <= 16'h0000;
            lnk.byte_valid <= 1'b0;
            lnk.byte_data <= 8'h00;
            lnk.byte_last <= 1'b0;
        end else begin
            if (acc && pwrite && paddr == `REG_STATUS &&
                pwdata[`STAT_DONE]) begin
                done_reg <= 1'b0;
            end
            case (state_reg)
                H_IDLE: begin
                    if (go) begin
                        op_reg <= op_t'(pwdata[2:0]);
                        if (op_t'(pwdata[2:0]) == OP_READ ||
                            op_t'(pwdata[2:0]) == OP_WRITE) begin
                            lnk.mem_type <= tgt_reg[19:`TGT_TYPE_LSB];
                            lnk.addr <= tgt_reg[15:0];
                        end else begin
                            lnk.mem_type <= `SP_TYPE;
                            lnk.addr <= `SP_SUBCMD_ADDR;
                        end
                        if (op_t'(pwdata[2:0]) == OP_READ) begin
                            lnk.rd_start <= 1'b1;
                            state_reg <= H_RSTART;
                        end else begin
                            lnk.wr_start <= 1'b1;
                            state_reg <= H_WSTART;
                        end
                    end
                end
                H_WSTART: begin
                    lnk.wr_start <= 1'b0;
                    lnk.byte_valid <= 1'b1;
                    lnk.byte_data <= frame_byte(4'h0, sub, pw_reg);
                    lnk.byte_last <= 1'b0;
                    idx_reg <= 4'h1;
                    state_reg <= H_BYTES;
                end
                H_BYTES: begin
                    if (lnk.byte_last) begin
                        lnk.byte_valid <= 1'b0;
                        lnk.byte_last <= 1'b0;
                        state_reg <= H_WWAIT;
                    end else begin
                        lnk.byte_data <= frame_byte(idx_reg, sub, pw_reg);
                        lnk.byte_last <= idx_reg == len - 4'h1;
                        idx_reg <= idx_reg + 4'h1;
                    end
                end
                H_WWAIT: begin
                    if (lnk.done) begin
                        if (lnk.ok && (op_reg == OP_CHECK ||
                                       op_reg == OP_LOCATE)) begin
                            lnk.mem_type <= `SP_TYPE;
                            lnk.addr <= `SP_RESULT_ADDR; // RULE_12
                            lnk.rd_start <= 1'b1;
                            state_reg <= H_RSTART;
                        end else begin
                            ok_reg <= lnk.ok;
                            done_reg <= 1'b1;
                            state_reg <= H_IDLE;
                        end
                    end
                end
                H_RSTART: begin
                    lnk.rd_start <= 1'b0;
                    state_reg <= H_RWAIT;
                end
                H_RWAIT: begin
                    if (lnk.done) begin
                        result_reg <= lnk.rd_data;
                        ok_reg <= lnk.ok;
                        done_reg <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                default: state_reg <= H_IDLE;
            endcase
        end
    end
endmodule : host_end

// ===== link_chk.sv
// checker on the link between host end and controller end
// assumes: instantiated beside the link interface, one pclk domain
`timescale 1ns/1ns
module link_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_start,
    input wire logic rd_start,
    input wire link_pkg::mem_type_t mem_type,
    input wire link_pkg::word_t addr,
    input wire logic byte_valid,
    input wire link_pkg::byte_t byte_data,
    input wire logic byte_last,
    input wire logic done,
    input wire logic ok,
    input wire link_pkg::word_t rd_data
);
    import link_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------
    // frame steps
    // ----------
    sequence sub_frame;
        wr_start && mem_type == 4'h6 && addr == 16'h0002;
    endsequence
    sequence long_code;
        sub_frame ##2 byte_valid && byte_data inside {8'h09, 8'h0A};
    endsequence
    sequence short_code;
        sub_frame ##2 byte_valid && byte_data inside {8'h03, 8'h06};
    endsequence
    a_sub_high: assert property (sub_frame |=> byte_valid && byte_data == 8'h00)
        else $error("sub-command high byte not first");
    a_sub_low: assert property (sub_frame |=> ##1 byte_valid &&
        byte_data inside {8'h03, 8'h06, 8'h09, 8'h0A})
        else $error("unknown sub-command code");
    a_gap_zero: assert property (long_code |=>
        (byte_valid && byte_data == 8'h00 && !byte_last)[*6])
        else $error("separator bytes not zero");
    a_long_len: assert property (long_code |=> ##6 byte_valid && !byte_last
        ##1 byte_valid && byte_last) else $error("long frame not ten bytes");
    a_short_len: assert property (short_code |-> byte_last)
        else $error("short frame not two bytes");
    a_done_delay: assert property (byte_last |=> !done ##1 done)
        else $error("frame answer not two cycles after last byte");
    a_read_delay: assert property (rd_start &&
        !(mem_type == 4'h6 && addr == 16'h0004) |=> !done ##1 done)
        else $error("read answer not two cycles after start");
    a_one_frame: assert property ((wr_start || rd_start) |=>
        !(wr_start || rd_start) [*2]) else $error("requests overlap");
    // ok is judged through the host status by the bench
    a_rd_hold: assert property (!$stable(rd_data) |-> done)
        else $error("read data moved without answer");
endmodule : link_chk

// ===== scratchpad_password_check_tb.sv
// bench: APB orders into the host end, controller end on the far side
// assumes: design files and link_defs.svh on the include path
`timescale 1ns/1ns
`include "link_defs.svh"
module scratchpad_password_check_tb;
    import link_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, okv;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r, k;
    logic pready, pslverr, logged_in, pw_set, check_busy;
    word_t scan_code, scan_addr, err_at = 16'h0, err_val = 16'h0;
    word_t ext_rd_data = 16'h0, pw, ea, ev;
    int seed = 89;
    int error_cnt = 0;
    int checked = 0;
    link_if lnk();
    host_end u_host_end (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
    ctrl_end u_ctrl_end (.pclk(pclk), .presetn(presetn), .lnk(lnk),
        .scan_code(scan_code), .ext_rd_data(ext_rd_data),
        .scan_addr(scan_addr), .logged_in(logged_in), .pw_set(pw_set),
        .check_busy(check_busy));
    link_chk u_link_chk (.pclk(pclk), .presetn(presetn),
        .wr_start(lnk.wr_start), .rd_start(lnk.rd_start),
        .mem_type(lnk.mem_type), .addr(lnk.addr),
        .byte_valid(lnk.byte_valid), .byte_data(lnk.byte_data),
        .byte_last(lnk.byte_last), .done(lnk.done), .ok(lnk.ok),
        .rd_data(lnk.rd_data));
    // one flagged program word, the rest clean
    assign scan_code = (scan_addr == err_at) ? err_val : 16'h0000;
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ----------
    // helpers
    // ----------
    task automatic end_sim();
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    task automatic chk32(input logic [31:0] e, input logic [31:0] g,
                         input string m);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk32
    task automatic chk1(input logic e, input logic g, input string m);
        chk32({31'h0, e}, {31'h0, g}, m);
    endtask : chk1
    function automatic word_t bcd4();
        word_t v;
        for (int i = 0; i < 4; i++) v[i*4 +: 4] = 4'({$random(seed)} % 10);
        return v;
    endfunction : bcd4
    function automatic word_t exp_loc(input word_t c, input word_t a);
        return (c != 16'h0000) ? a : 16'h0000;
    endfunction : exp_loc
    // held until pready seen high, so slow answers are fine
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic op(input logic [2:0] c);
        apb(1'b1, `REG_CTRL, {29'h0, c}, r);
        do apb(1'b0, `REG_STATUS, 32'h0, r);
        while (r[`STAT_DONE] !== 1'b1);
        okv = r[`STAT_OK];
        apb(1'b1, `REG_STATUS, 32'h4, r);
    endtask : op
    initial begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        $display("[FAIL] %0t timeout", $time);
        end_sim();
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'hFC, 32'h0, r);
        chk32(32'h0, r, "unmapped read");
        apb(1'b1, `REG_PASSWORD, 32'h0, r);
        op(3'h2);
        chk1(1'b0, okv, "change before log-in");
        op(3'h1);
        chk1(1'b1, logged_in, "log-in with zero");
        for (int i = 0; i < 2; i++) begin
            pw = (i == 0) ? 16'h9999 : (bcd4() | 16'h0001);
            apb(1'b1, `REG_PASSWORD, {16'h0, pw}, r);
            op(3'h2);
            chk1(1'b1, okv, "change refused");
            chk1(1'b1, pw_set, "password flag");
        end
        apb(1'b1, `REG_PASSWORD, 32'h12A4, r);
        op(3'h2);
        chk1(1'b0, okv, "non-decimal password taken");
        apb(1'b1, `REG_PASSWORD, {16'h0, pw ^ 16'h0001}, r);
        op(3'h1);
        chk1(1'b0, logged_in, "wrong password let in");
        ext_rd_data <= 16'($random(seed));
        apb(1'b1, `REG_TARGET, 32'h0001_0010, r);
        op(3'h5);
        chk1(1'b0, okv, "locked read served");
        op(3'h6);
        chk1(1'b0, okv, "locked write served");
        apb(1'b1, `REG_TARGET, 32'h0009_0010, r);
        op(3'h5);
        apb(1'b0, `REG_RESULT, 32'h0, r);
        chk32({16'h0, ext_rd_data}, r, "diagnostic read");
        // checks run while locked out
        for (int i = 0; i < 4; i++) begin
            ea = (i == 1) ? `PROG_LAST : (i == 2) ? 16'h0 :
                 16'($random(seed)) & `PROG_LAST;
            ev = (i == 3) ? 16'h0 : 16'($random(seed)) | 16'h0001;
            err_at <= ea;
            err_val <= ev;
            op(3'h3);
            chk1(1'b1, okv, "check refused");
            chk1(1'b0, check_busy, "scan still busy");
            apb(1'b0, `REG_RESULT, 32'h0, k);
            chk32({16'h0, ev}, k, "error code");
            apb(1'b1, `REG_TARGET, 32'h0006_0004, r);
            op(3'h5);
            apb(1'b0, `REG_RESULT, 32'h0, r);
            chk32(k, r, "result moved");
            op(3'h4);
            apb(1'b0, `REG_RESULT, 32'h0, r);
            chk32({16'h0, exp_loc(ev, ea)}, r, "error location");
        end
        apb(1'b1, `REG_PASSWORD, {16'h0, pw}, r);
        op(3'h1);
        chk1(1'b1, logged_in, "right password refused");
        apb(1'b1, `REG_TARGET, 32'h0001_0010, r);
        op(3'h5);
        chk1(1'b1, okv, "unlocked read refused");
        apb(1'b1, `REG_PASSWORD, 32'h0, r);
        op(3'h2);
        chk1(1'b0, pw_set, "zero password");
        end_sim();
    end
endmodule : scratchpad_password_check_tb
